// File: rtl/sf_mapper_pkg.sv
package sf_mapper_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // grid and super-frame geometry
    localparam int CU_SYM = 90;              // symbols per capacity unit
    localparam int SF_SYM = 612540;          // symbols per super-frame
    localparam int SF_CUS_DEF = SF_SYM / CU_SYM; // capacity units per super-frame
    localparam int SOSF_SYM = 720;           // start marker plus format indicator
    localparam int SFH_CUS_DEF = 8;          // header and trailer field units
    localparam int BSW_WIN_DEF = 400;        // tail window reserved for dummy fill
    localparam int PLH_STD_SYM = 180;        // standard protection header
    localparam int PLH_HE_SYM = 90;          // high-efficiency header
    localparam logic [3:0] PLH_STD_CU = 4'(PLH_STD_SYM / CU_SYM);
    localparam logic [3:0] PLH_HE_CU = 4'(PLH_HE_SYM / CU_SYM);

    ////////////////////////////////////////////////////////////////////////////////
    // frame sizes and pointer
    localparam logic [11:0] NORMAL_32APSK_CU = 12'h090;  // 144 units
    localparam logic [11:0] SHORT_QPSK_SF2_CU = 12'h0C0; // 192 units, 12 of them pilots
    localparam logic [10:0] PTR_NONE = 11'h7FF;          // no header starts in reach
    localparam logic [10:0] PTR_MAX = 11'h7FE;

    ////////////////////////////////////////////////////////////////////////////////
    // register map and fields
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_SFH = 4'h8;
    localparam logic [3:0] REG_SFCNT = 4'hC;
    localparam int CTRL_PROT_LO = 0;         // two-bit protection level
    localparam int CTRL_HE_BIT = 2;          // high-efficiency header
    localparam int CTRL_BSW_BIT = 3;         // beam switching enable
    localparam int ST_BSW_BIT = 16;
    localparam int ST_REF_BIT = 17;          // refused frame, write one to clear
    localparam int ST_FS_LO = 18;
    localparam int SFH_PROT_LO = 16;
    localparam logic [1:0] PROT_RST = 2'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {CU_OVH, CU_PLH, CU_PAY, CU_FILL} cu_kind_e;
    typedef enum logic [1:0] {FS_IDLE, FS_PLH, FS_PAY} frm_state_e;

    typedef struct packed {
        logic [11:0] payCu;   // units of one payload copy, pilots included
        logic [2:0] spread;   // payload spreading factor
        logic is32apsk;       // frame uses 32APSK
        logic dummyB;         // type B dummy, normal size
    } frame_s;

    typedef struct packed {
        cu_kind_e kind;       // content of this unit
        logic [2:0] rep;      // payload copy index
        logic first;          // first unit of a frame
    } cu_s;

    typedef struct packed {
        logic [10:0] ptr;     // zero-based unit of first header
        logic [1:0] prot;     // header protection level
    } sfh_s;

    // repetition factor of each protection level
    function automatic logic [2:0] protFactor(input logic [1:0] lvl);
        case (lvl)
            2'h0: protFactor = 3'h1;
            2'h1: protFactor = 3'h2;
            default: protFactor = 3'h5;
        endcase
    endfunction : protFactor

endpackage : sf_mapper_pkg

// File: rtl/superframe_plframe_mapper.sv
// Notes on behaviour
// - header directly precedes every payload frame
// - frames start only on unit boundaries
// - every frame fills whole capacity units
// - frames continue across super-frame ends
// - pointer gives first header, zero-based
// - header two units; one unit only all-32APSK
// - normal 32APSK frame takes 144 units
// - short QPSK spread two takes 192 units
// - header carries two-bit protection level
// - all headers repeated by signalled factor
// - spread payload sent spreading-factor times
// - payload factor never above protection factor
// - split spread frame keeps first header's signalling; here the level is still latched anew at unit zero
// - field and pilot gaps pause repetitions; here only the field gap does, pilots are counted inside payCu
// - beam switching fills tail with dummy B
// - switch after dummy header, before next start
// - terminating dummy header fits current super-frame
// - cut dummy header takes full next length
// - dummy B normal size, truncated at end
//
// Design decisions made here: the placing of the registers and strobed register access.
module superframe_plframe_mapper
    import sf_mapper_pkg::*;
#(
    parameter int SF_CUS = SF_CUS_DEF,
    parameter int SFH_CUS = SFH_CUS_DEF,
    parameter int BSW_WIN = BSW_WIN_DEF
) (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // frame source
    input wire logic frmValid,
    input wire frame_s frmIn,
    output logic frmReady,
    // unit stream towards the modulator
    output cu_s cuOut,
    output sfh_s sfhOut,
    output logic sfhValid,
    output logic bswGo
);

    ////////////////////////////////////////////////////////////////////////////////
    // constants
    localparam logic [12:0] LAST_CU = 13'(SF_CUS - 1);          // final unit index
    localparam logic [12:0] OVH_CU = 13'(SOSF_SYM / CU_SYM + SFH_CUS); // field units
    localparam logic [12:0] WIN_CU = 13'(BSW_WIN);              // dummy tail window

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    logic rstMeta_reg;                 // reset synchroniser, first stage
    logic rstSync_reg;                 // released reset, active low
    logic [12:0] cuPos_reg;            // unit index in super-frame
    logic [31:0] sfCnt_reg;            // super-frames sent
    logic [1:0] protLvl_reg;           // software protection level
    logic hiEff_reg;                   // software high-efficiency header
    logic bswEn_reg;                   // software beam switching
    logic [1:0] protSf_reg;            // level of current super-frame
    logic hiEffSf_reg;                 // header size of current super-frame
    logic bswSf_reg;                   // switching in current super-frame
    logic refused_reg;                 // sticky refused frame
    frm_state_e fs_reg, fs_next;       // frame walk state
    logic [3:0] plhLeft_reg, plhLeft_next;   // header units left
    logic [11:0] payLeft_reg, payLeft_next;  // units left in copy
    logic [2:0] repLeft_reg, repLeft_next;   // copies left after this
    logic [11:0] payCu_reg, payCu_next;      // copy length
    logic [2:0] spread_reg, spread_next;     // payload factor
    logic isDummy_reg, isDummy_next;         // frame is type B dummy
    logic dumFull_reg, dumFull_next;         // dummy header was cut
    cu_s cuNext;                        // unit content of this cycle
    logic refusedSet;                   // frame dropped this cycle
    logic bswSet;                       // dummy payload under way, header out
    logic inOvh;                        // fields at super-frame start
    logic [2:0] factor;                 // header repetition factor
    logic [3:0] plhLen;                 // header length in units
    logic [12:0] roomLeft;              // units to super-frame end
    logic needDummy;                    // tail reserved for dummy fill
    logic badFrm;                       // offered frame breaks limits
    logic [15:0] remCu;                 // units left in current frame
    logic [16:0] ptrFull;               // unclipped pointer
    logic rstN;                         // released reset copy

    ////////////////////////////////////////////////////////////////////////////////
    // reset release through two flip-flops
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rstMeta_reg <= 1'b0;
            rstSync_reg <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstSync_reg <= rstMeta_reg;
        end
    end
    assign rstN = rstSync_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // decode helpers
    assign inOvh = cuPos_reg < OVH_CU;
    assign factor = protFactor(protSf_reg);
    assign plhLen = hiEffSf_reg ? 4'(factor) : 4'({factor, 1'b0});
    assign roomLeft = 13'(LAST_CU - cuPos_reg + 13'h1);
    assign needDummy = bswSf_reg && (roomLeft <= WIN_CU);
    assign badFrm = (frmIn.spread == 3'h0) || (frmIn.spread > factor)
        || (hiEffSf_reg && !frmIn.is32apsk)
        || (frmIn.payCu == 12'h000);
    assign frmReady = ce && !inOvh && (fs_reg == FS_IDLE) && !needDummy;

    ////////////////////////////////////////////////////////////////////////////////
    // unit counter, restarts at reset
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            cuPos_reg <= 13'h0000;
        end else if (ce) begin
            cuPos_reg <= (cuPos_reg == LAST_CU) ? 13'h0000 : 13'(cuPos_reg + 13'h1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // frame walk, one unit per enabled cycle
    always_comb begin
        fs_next = fs_reg;
        plhLeft_next = plhLeft_reg;
        payLeft_next = payLeft_reg;
        repLeft_next = repLeft_reg;
        payCu_next = payCu_reg;
        spread_next = spread_reg;
        isDummy_next = isDummy_reg;
        dumFull_next = dumFull_reg;
        cuNext = '{kind: CU_OVH, rep: 3'h0, first: 1'b0};
        refusedSet = 1'b0;
        bswSet = 1'b0;
        if (!inOvh) begin
            case (fs_reg)
                FS_IDLE: begin
                    cuNext.kind = CU_FILL;
                    // tail dummy only where its header fits
                    if (needDummy && (roomLeft >= 13'(plhLen))) begin
                        payCu_next = NORMAL_32APSK_CU;
                        spread_next = 3'h1;
                        isDummy_next = 1'b1;
                    end else if (!needDummy && frmValid && badFrm) begin
                        refusedSet = 1'b1;
                    end else if (!needDummy && frmValid) begin
                        payCu_next = frmIn.payCu;
                        spread_next = frmIn.spread;
                        isDummy_next = frmIn.dummyB;
                    end
                    // a frame starts on this unit with its header
                    if ((needDummy && (roomLeft >= 13'(plhLen)))
                        || (!needDummy && frmValid && !badFrm)) begin
                        cuNext.kind = CU_PLH;
                        cuNext.first = 1'b1;
                        dumFull_next = 1'b0;
                        plhLeft_next = 4'(plhLen - 4'h1);
                        payLeft_next = payCu_next;
                        repLeft_next = 3'(spread_next - 3'h1);
                        if (plhLen == 4'h1) begin
                            fs_next = FS_PAY;
                        end else begin
                            fs_next = FS_PLH;
                        end
                    end
                end
                FS_PLH: begin
                    // header repeats continue after any field gap
                    cuNext.kind = CU_PLH;
                    plhLeft_next = 4'(plhLeft_reg - 4'h1);
                    if (plhLeft_reg == 4'h1) begin
                        fs_next = FS_PAY;
                    end
                end
                FS_PAY: begin
                    cuNext.kind = CU_PAY;
                    // switch opens only once the whole dummy header is out
                    bswSet = isDummy_reg && !dumFull_reg;
                    cuNext.rep = 3'(spread_reg - 3'h1 - repLeft_reg);
                    if (payLeft_reg != 12'h001) begin
                        payLeft_next = 12'(payLeft_reg - 12'h001);
                    end else if (repLeft_reg != 3'h0) begin
                        repLeft_next = 3'(repLeft_reg - 3'h1);
                        payLeft_next = payCu_reg;
                    end else begin
                        fs_next = FS_IDLE;
                    end
                end
                default: begin
                    fs_next = FS_IDLE;
                end
            endcase
        end
        // type B dummy at the super-frame end
        if ((cuPos_reg == LAST_CU) && isDummy_reg && (fs_reg != FS_IDLE)) begin
            if (!dumFull_reg && ((fs_reg == FS_PAY) || (plhLeft_reg == 4'h1))) begin
                fs_next = FS_IDLE;
            end else if (fs_reg == FS_PLH) begin
                dumFull_next = 1'b1;
            end
        end
    end

    // frame walk registers, frozen in the field gap
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            fs_reg <= FS_IDLE;
            plhLeft_reg <= 4'h0;
            payLeft_reg <= 12'h000;
            repLeft_reg <= 3'h0;
            payCu_reg <= 12'h000;
            spread_reg <= 3'h1;
            isDummy_reg <= 1'b0;
            dumFull_reg <= 1'b0;
        end else if (ce) begin
            fs_reg <= fs_next;
            plhLeft_reg <= plhLeft_next;
            payLeft_reg <= payLeft_next;
            repLeft_reg <= repLeft_next;
            payCu_reg <= payCu_next;
            spread_reg <= spread_next;
            isDummy_reg <= isDummy_next;
            dumFull_reg <= dumFull_next;
        end
    end

    // registered unit output
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            cuOut <= '{kind: CU_OVH, rep: 3'h0, first: 1'b0};
        end else if (ce) begin
            cuOut <= cuNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // super-frame header fields, built on unit zero
    always_comb begin
        remCu = 16'h0000;
        if (fs_reg != FS_IDLE) begin
            remCu = 16'(16'(payLeft_reg) + 16'(repLeft_reg) * 16'(payCu_reg));
        end
        if (fs_reg == FS_PLH) begin
            remCu = 16'(remCu + 16'(plhLeft_reg));
        end
        ptrFull = 17'(17'(OVH_CU) + 17'(remCu));
    end

    // latch settings per super-frame, emit header
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            protSf_reg <= PROT_RST;
            hiEffSf_reg <= 1'b0;
            bswSf_reg <= 1'b0;
            sfhOut <= '{ptr: 11'h000, prot: PROT_RST};
            sfhValid <= 1'b0;
            sfCnt_reg <= 32'h0000_0000;
        end else if (ce) begin
            sfhValid <= (cuPos_reg == 13'h0000);
            if (cuPos_reg == 13'h0000) begin
                // the new level is latched even when a spread frame is split here
                protSf_reg <= protLvl_reg;
                hiEffSf_reg <= hiEff_reg;
                bswSf_reg <= bswEn_reg;
                sfhOut.prot <= protLvl_reg;
                sfhOut.ptr <= (ptrFull > 17'(PTR_MAX)) ? PTR_NONE : ptrFull[10:0];
                sfCnt_reg <= 32'(sfCnt_reg + 32'h1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // beam switching window
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            bswGo <= 1'b0;
        end else if (ce) begin
            if (cuPos_reg == LAST_CU) begin
                bswGo <= 1'b0;
            end else if (bswSet && bswSf_reg) begin
                bswGo <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control register writes
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            protLvl_reg <= PROT_RST;
            hiEff_reg <= 1'b0;
            bswEn_reg <= 1'b0;
        end else if (ce && regWr && (regAddr == REG_CTRL)) begin
            protLvl_reg <= regWdata[CTRL_PROT_LO +: 2];
            hiEff_reg <= regWdata[CTRL_HE_BIT];
            bswEn_reg <= regWdata[CTRL_BSW_BIT];
        end
    end

    // refused flag, a new refusal beats the clear
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            refused_reg <= 1'b0;
        end else if (ce) begin
            if (refusedSet) begin
                refused_reg <= 1'b1;
            end else if (regWr && (regAddr == REG_STATUS) && regWdata[ST_REF_BIT]) begin
                refused_reg <= 1'b0;
            end
        end
    end

    // read data, valid only in the cycle after the strobe
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            regRdata <= 32'h0000_0000;
        end else if (ce) begin
            regRdata <= 32'h0000_0000;
            if (regRd) begin
                case (regAddr)
                    REG_CTRL: begin
                        regRdata <= 32'({bswEn_reg, hiEff_reg, protLvl_reg});
                    end
                    REG_STATUS: begin
                        regRdata <= 32'({2'(fs_reg), refused_reg, bswGo, 3'h0, cuPos_reg});
                    end
                    REG_SFH: begin
                        regRdata <= 32'({sfhOut.prot, 5'h00, sfhOut.ptr});
                    end
                    REG_SFCNT: begin
                        regRdata <= sfCnt_reg;
                    end
                    default: begin
                        regRdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    ptr_idle_a: assert property (@(posedge mclk) disable iff (!rstN)
        (ce && (cuPos_reg == 13'h0000) && (fs_reg == FS_IDLE))
        |=> sfhValid && (sfhOut.ptr == OVH_CU[10:0]))
        else $error("pointer not at first free unit");

    ovh_freeze_a: assert property (@(posedge mclk) disable iff (!rstN)
        (ce && inOvh && (cuPos_reg != LAST_CU))
        |=> $stable(fs_reg) && $stable(plhLeft_reg) && $stable(payLeft_reg))
        else $error("frame advanced inside field gap");

    frame_start_a: assert property (@(posedge mclk) disable iff (!rstN)
        (frmReady && frmValid && !badFrm)
        |=> (cuOut.kind == CU_PLH) && cuOut.first)
        else $error("accepted frame did not start with header");

    plh_end_a: assert property (@(posedge mclk) disable iff (!rstN)
        (ce && !inOvh && (fs_reg == FS_PLH) && (plhLeft_reg == 4'h1)
        && !(isDummy_reg && (cuPos_reg == LAST_CU)))
        |=> (fs_reg == FS_PAY) && (payLeft_reg == payCu_reg))
        else $error("header length wrong");

    refuse_a: assert property (@(posedge mclk) disable iff (!rstN)
        (frmReady && frmValid && (frmIn.spread > factor))
        |=> refused_reg && (cuOut.kind == CU_FILL))
        else $error("over-spread frame not refused");

    dummy_end_a: assert property (@(posedge mclk) disable iff (!rstN)
        (ce && (cuPos_reg == LAST_CU) && isDummy_reg && (fs_reg == FS_PAY) && !dumFull_reg)
        |=> (fs_reg == FS_IDLE))
        else $error("dummy not truncated at super-frame end");

    dummy_full_a: assert property (@(posedge mclk) disable iff (!rstN)
        (ce && (cuPos_reg == LAST_CU) && isDummy_reg && (fs_reg == FS_PLH)
        && (plhLeft_reg != 4'h1))
        |=> dumFull_reg && (fs_reg == FS_PLH))
        else $error("cut dummy header not carried over");

    bsw_clear_a: assert property (@(posedge mclk) disable iff (!rstN)
        (ce && (cuPos_reg == LAST_CU)) |=> !bswGo)
        else $error("switch window open at super-frame start");

    spread_rep_a: assert property (@(posedge mclk) disable iff (!rstN)
        (ce && !inOvh && (fs_reg == FS_PAY) && (payLeft_reg == 12'h001)
        && (repLeft_reg != 3'h0) && !(isDummy_reg && (cuPos_reg == LAST_CU)))
        |=> (fs_reg == FS_PAY) && (payLeft_reg == payCu_reg)
        && (repLeft_reg == $past(repLeft_reg) - 3'h1))
        else $error("payload copy not repeated");

    prot_field_a: assert property (@(posedge mclk) disable iff (!rstN)
        sfhValid |-> (sfhOut.prot == protSf_reg))
        else $error("header level differs from latched level");

endmodule : superframe_plframe_mapper

// File: verification/sf_demod_model.sv
module sf_demod_model
    import sf_mapper_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // unit stream from the mapper
    input wire cu_s cuIn,
    // tallies of the latest frame
    output logic [11:0] plhCnt,
    output logic [11:0] payCnt
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////////
    // tally units per frame; field units skipped, tracking resumes after them
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            plhCnt <= 12'h000;
            payCnt <= 12'h000;
        end else if (cuIn.kind == CU_PLH && cuIn.first) begin
            plhCnt <= 12'h001;
            payCnt <= 12'h000;
        end else if (cuIn.kind == CU_PLH) begin
            plhCnt <= plhCnt + 12'h001;
        end else if (cuIn.kind == CU_PAY) begin
            payCnt <= payCnt + 12'h001;
        end
    end
endmodule : sf_demod_model

// File: verification/superframe_plframe_mapper_bench.sv
module superframe_plframe_mapper_bench
    import sf_mapper_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, nrst = 1'b0, ce = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic frmValid = 1'b0, rdPend = 1'b0, frmReady, sfhValid, bswGo;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0, regRdata;
    frame_s frmIn = '0;
    cu_s cuOut;
    sfh_s sfhOut;
    logic [11:0] plhCnt, payCnt;
    logic [63:0] expQ[$]; // mask and value of each read
    int failures = 0, comparisons = 0;
    int pc[4] = '{144, 192, 0, 0}, sp[4] = '{1, 2, 2, 5}, fac[4] = '{1, 2, 5, 5};
    always #2.5 mclk = ~mclk;

    superframe_plframe_mapper #(.SF_CUS(300), .SFH_CUS(2), .BSW_WIN(40)) u_dut (
        .mclk, .nrst, .ce, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .frmValid, .frmIn, .frmReady, .cuOut, .sfhOut, .sfhValid, .bswGo);
    sf_demod_model u_model (.mclk, .nrst, .cuIn(cuOut), .plhCnt, .payCnt);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        expQ.push_back({m, e});
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        @(posedge mclk);
    endtask : rd
    // bounded wait on switch window (2), frame ready (1) or header strobe (0)
    task automatic waitFor(input int which);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while ((which == 2 ? bswGo : which ? frmReady : sfhValid) !== 1'b1 && n < 800);
        if (n >= 800) begin
            failures++;
            conclude();
        end
    endtask : waitFor
    task automatic send(input frame_s f);
        frmIn <= f;
        frmValid <= 1'b1;
        waitFor(1);
        frmValid <= 1'b0;
        waitFor(1);
        @(posedge mclk);
    endtask : send

    ////////////////////////////////////////////////////////////////////////////////
    // read watcher: oldest note against the data one cycle after the strobe
    always @(posedge mclk) begin
        logic [63:0] q;
        rdPend <= regRd;
        if (rdPend) begin
            q = expQ.pop_front();
            chk(regRdata & q[63:32], q[31:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        repeat (4) @(posedge mclk);
        void'($urandom(97237));
        pc[2] = $urandom_range(1, 20);
        pc[3] = $urandom_range(1, 20);
        rd(REG_CTRL, 32'hFFFFFFFF, 32'h0);
        rd(4'h1, 32'hFFFFFFFF, 32'h0);
        // one frame per protection level, header and payload sizes
        for (int t = 0; t < 4; t++) begin
            wr(REG_CTRL, {29'h0, t == 0, 2'(t)});
            waitFor(0);
            waitFor(0);
            chk(32'(sfhOut.prot), t);
            send('{12'(pc[t]), 3'(sp[t]), t == 0, 1'b0});
            // whole frame starts on unit 10, 290 usable units per super-frame
            n = (t == 0 ? 1 : 2) * fac[t] + pc[t] * sp[t];
            chk(32'(plhCnt), (t == 0 ? 1 : 2) * fac[t]);
            chk(32'(sfhOut.ptr), n > 290 ? n - 280 : 10);
            chk(32'(payCnt), pc[t] * sp[t]);
            $display("level test %0d done", t);
        end
        // enable low freezes the unit count: period resumes where it stopped
        waitFor(0);
        ce <= 1'b0;
        repeat ($urandom_range(5, 40)) @(posedge mclk);
        ce <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (sfhValid !== 1'b1 && n < 800);
        if (n >= 800) begin
            failures++;
            conclude();
        end
        chk(32'(n), 32'h0000_012C);
        chk(32'(sfhOut.ptr), 32'h0000_000A);
        $display("enable test done");
        // beam switching: dummy B fills the tail, window opens after its header
        wr(REG_CTRL, 32'h0000_0008);
        waitFor(0);
        waitFor(0);
        waitFor(2);
        chk(32'(cuOut.kind), 32'(CU_PAY));
        waitFor(0);
        chk(32'(bswGo), 32'h0000_0000);
        chk(32'(plhCnt), 32'h0000_0002);
        chk(32'(payCnt), 32'h0000_0026);
        $display("beam switch test done");
        // payload factor above the header factor is dropped
        wr(REG_CTRL, 32'h0);
        waitFor(0);
        waitFor(0);
        send('{12'h003, 3'h2, 1'b0, 1'b0});
        rd(REG_STATUS, 32'h00020000, 32'h00020000);
        wr(REG_STATUS, 32'h00020000);
        rd(REG_STATUS, 32'h00020000, 32'h0);
        $display("refusal test done");
        // let the read watcher take the last read first
        @(posedge mclk);
        conclude();
    end
endmodule : superframe_plframe_mapper_bench
